/* File: core/adc_seq_pkg.sv */
// Shared constants for the converter reset and sequencing link
package adc_seq_pkg;
	// Core clock
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CNT_W = 20;
	// Frame layout: rw, 15-bit address, 8-bit data
	localparam int FRAME_BITS = 24;
	localparam int HDR_BITS = 16;
	localparam int ADDR_W = 15;
	// Register addresses
	localparam logic [14:0] ADDR_IFACE_A = 15'h0000;
	localparam logic [14:0] ADDR_EXIT_CFG = 15'h0014;
	localparam logic [14:0] ADDR_MODES = 15'h0020;
	localparam logic [14:0] ADDR_DIAG = 15'h0034;
	localparam logic [14:0] ADDR_ENTER_CFG = 15'h3FFF;
	localparam logic [7:0] EXIT_CFG_VAL = 8'h01;
	// Field positions
	localparam int SOFT_RESET_A_POS = 7;
	localparam int SOFT_RESET_B_POS = 0;
	localparam int RESET_SEEN_POS = 0;
	// Reset values
	localparam logic [7:0] IFACE_A_RST = 8'h00;
	localparam logic [7:0] MODES_RST = 8'h00;
	// Timing
	localparam int RESET_PULSE_MIN_WIDTH_NS = 50;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int RESET_DELAY_MS = 3;
	// Cycles per ms first, so the product stays inside a 32-bit int
	localparam int RESET_DELAY_CYC = RESET_DELAY_MS * (1000000000 / CLK_PERIOD_PS);
	localparam int LOCKOUT_US = 750;
	localparam int LOCKOUT_CYC = (LOCKOUT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CONV_CYC_DEF = 75;
	localparam int QUIET_WINDOW_CYC = 16;
	localparam int SCK_HALF_CYC = 10;
endpackage : adc_seq_pkg

/* File: core/adc_link_if.sv */
// Pin-level link between the host controller and the converter
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
	logic rst_n;
	logic cs_n;
	logic sck;
	logic sdi;
	logic convert_strobe;
	logic sdo;
	logic conversion_flag_or_clock_out;
	modport dev (
		input rst_n, cs_n, sck, sdi, convert_strobe,
		output sdo, conversion_flag_or_clock_out
	);
	modport host (
		output rst_n, cs_n, sck, sdi, convert_strobe,
		input sdo, conversion_flag_or_clock_out
	);
endinterface : adc_link_if
`default_nettype wire

/* File: core/adc_seq_dev.sv */
// Converter end: reset sources, lockout, config registers, conversion flag
//
// Contract
// - sample taken at convert strobe rising edge
// - host keeps mux still during busy, quiet
// - host switches mux right after conversion
// - low reset pin resets the device
// - host holds reset low 50 ns
// - soft reset needs both bits, one write
// - hardware or soft reset sets seen flag
// - writing one clears seen flag
// - power-up resets registers, sets seen flag
// - supply dropout also forces power-on reset
// - host resets explicitly after power-on reset; host pulses reset by itself only after sys_rst_in, else on reset_req_in, not after a supply dropout
// - host waits 3 ms before reset
// - 750 us lockout of commands, conversions
// - busy high from strobe to completion
// - config mode entry read, exit write
// - frames are 24 clocks, select low
`timescale 1ns/1ps
`default_nettype none
module adc_seq_dev #(
	parameter int LOCK_CYC = adc_seq_pkg::LOCKOUT_CYC,
	parameter int CONV_CYC = adc_seq_pkg::CONV_CYC_DEF
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Link
	adc_link_if.dev link,
	// Supply monitors, asynchronous
	input wire logic analog_supply_high_ok_in,
	input wire logic core_supply_low_ok_in,
	// Status
	output logic sample_strobe_out,
	output logic reset_active_out,
	output logic lockout_out,
	output logic cfg_mode_out,
	output logic reset_seen_flag_out,
	output logic [7:0] modes_out
);
	localparam int W = adc_seq_pkg::CNT_W;

	// Synchronisers: stage 1 feeds stage 2 only
	logic [6:0] s1_r;
	logic [6:0] s2_r;
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s1_r <= 7'h00;
			s2_r <= 7'h00;
		end else begin
			s1_r <= {link.rst_n, link.cs_n, link.sck, link.sdi, link.convert_strobe,
				analog_supply_high_ok_in, core_supply_low_ok_in};
			s2_r <= s1_r;
		end
	end
	logic rst_pin_n;
	logic cs_n_s;
	logic sck_s;
	logic sdi_s;
	logic cnv_s;
	logic supplies_ok;
	assign rst_pin_n = s2_r[6];
	assign cs_n_s = s2_r[5];
	assign sck_s = s2_r[4];
	assign sdi_s = s2_r[3];
	assign cnv_s = s2_r[2];
	assign supplies_ok = s2_r[1] & s2_r[0];

	logic hold_r, hold_nxt;
	logic [W-1:0] lock_r, lock_nxt;
	logic lock_out_r, lock_out_nxt;
	logic flag_r, flag_nxt;
	logic cfg_r, cfg_nxt;
	logic [7:0] ifa_r, ifa_nxt;
	logic [7:0] pend_r, pend_nxt;
	logic [7:0] modes_r, modes_nxt;
	logic [4:0] bit_r, bit_nxt;
	logic [22:0] sh_r, sh_nxt;
	logic rd_en_r, rd_en_nxt;
	logic [7:0] rd_r, rd_nxt;
	logic sdo_r, sdo_nxt;
	logic busy_r, busy_nxt;
	logic [W-1:0] conv_r, conv_nxt;
	logic smp_r, smp_nxt;
	logic sck_d_r, sck_d_nxt;
	logic cnv_d_r, cnv_d_nxt;

	function automatic logic [7:0] reg_read(input logic [14:0] a, input logic [7:0] ifa,
		input logic [7:0] md, input logic fl);
		case (a)
			adc_seq_pkg::ADDR_IFACE_A: reg_read = ifa;
			adc_seq_pkg::ADDR_MODES: reg_read = md;
			adc_seq_pkg::ADDR_DIAG: reg_read = {7'h00, fl};
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	always_comb begin
		logic [23:0] frame;
		logic do_reset;
		logic locked;
		frame = {sh_r, sdi_s};
		do_reset = 1'b0;
		locked = (lock_r != '0);
		hold_nxt = hold_r;
		lock_nxt = lock_r;
		flag_nxt = flag_r;
		cfg_nxt = cfg_r;
		ifa_nxt = ifa_r;
		pend_nxt = pend_r;
		modes_nxt = modes_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		rd_en_nxt = rd_en_r;
		rd_nxt = rd_r;
		sdo_nxt = sdo_r;
		busy_nxt = busy_r;
		conv_nxt = conv_r;
		smp_nxt = 1'b0;
		sck_d_nxt = sck_s;
		cnv_d_nxt = cnv_s;
		if (!rst_pin_n || !supplies_ok) begin
			do_reset = 1'b1;
		end else if (hold_r) begin
			hold_nxt = 1'b0;
			lock_nxt = W'(LOCK_CYC);
			flag_nxt = 1'b1;
		end else begin
			if (locked) begin
				lock_nxt = lock_r - W'(1);
			end
			if (busy_r) begin
				conv_nxt = conv_r - W'(1);
				if (conv_r == W'(1)) begin
					busy_nxt = 1'b0;
				end
			end else if (cnv_s && !cnv_d_r && !locked) begin
				busy_nxt = 1'b1;
				conv_nxt = W'(CONV_CYC);
				smp_nxt = 1'b1;
			end
			if (cs_n_s) begin
				bit_nxt = 5'h00;
				sdo_nxt = 1'b0;
			end else if (!locked && sck_s && !sck_d_r && bit_r < 5'(adc_seq_pkg::FRAME_BITS)) begin
				sh_nxt = frame[22:0];
				bit_nxt = bit_r + 5'h01;
				if (bit_r == 5'(adc_seq_pkg::HDR_BITS - 1)) begin
					rd_en_nxt = frame[15];
					rd_nxt = reg_read(frame[14:0], ifa_r, modes_r, flag_r);
					if (frame[15] && frame[14:0] == adc_seq_pkg::ADDR_ENTER_CFG) begin
						cfg_nxt = 1'b1;
					end
				end
				if (bit_r == 5'(adc_seq_pkg::FRAME_BITS - 1) && !frame[23] && cfg_r) begin
					case (frame[22:8])
						adc_seq_pkg::ADDR_IFACE_A: begin
							if (frame[adc_seq_pkg::SOFT_RESET_A_POS]
								&& frame[adc_seq_pkg::SOFT_RESET_B_POS]) begin
								do_reset = 1'b1;
							end else begin
								ifa_nxt = frame[7:0];
							end
						end
						adc_seq_pkg::ADDR_DIAG: begin
							if (frame[adc_seq_pkg::RESET_SEEN_POS]) begin
								flag_nxt = 1'b0;
							end
						end
						adc_seq_pkg::ADDR_MODES: pend_nxt = frame[7:0];
						adc_seq_pkg::ADDR_EXIT_CFG: begin
							if (frame[7:0] == adc_seq_pkg::EXIT_CFG_VAL) begin
								cfg_nxt = 1'b0;
								modes_nxt = pend_r;
							end
						end
						default: ;
					endcase
				end
			end else if (!locked && !sck_s && sck_d_r && rd_en_r
				&& bit_r >= 5'(adc_seq_pkg::HDR_BITS)
				&& bit_r < 5'(adc_seq_pkg::FRAME_BITS)) begin
				sdo_nxt = rd_r[7];
				rd_nxt = {rd_r[6:0], 1'b0};
			end
		end
		if (do_reset) begin
			hold_nxt = 1'b1;
			lock_nxt = '0;
			cfg_nxt = 1'b0;
			ifa_nxt = adc_seq_pkg::IFACE_A_RST;
			pend_nxt = adc_seq_pkg::MODES_RST;
			modes_nxt = adc_seq_pkg::MODES_RST;
			bit_nxt = 5'h00;
			rd_en_nxt = 1'b0;
			sdo_nxt = 1'b0;
			busy_nxt = 1'b0;
			conv_nxt = '0;
			smp_nxt = 1'b0;
		end
		lock_out_nxt = hold_nxt || (lock_nxt != '0);
	end

	// Power-up counts as a reset with the seen flag raised
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hold_r <= 1'b1;
			lock_r <= '0;
			lock_out_r <= 1'b1;
			flag_r <= 1'b1;
			cfg_r <= 1'b0;
			ifa_r <= adc_seq_pkg::IFACE_A_RST;
			pend_r <= adc_seq_pkg::MODES_RST;
			modes_r <= adc_seq_pkg::MODES_RST;
			bit_r <= 5'h00;
			sh_r <= 23'h000000;
			rd_en_r <= 1'b0;
			rd_r <= 8'h00;
			sdo_r <= 1'b0;
			busy_r <= 1'b0;
			conv_r <= '0;
			smp_r <= 1'b0;
			sck_d_r <= 1'b0;
			cnv_d_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			lock_r <= lock_nxt;
			lock_out_r <= lock_out_nxt;
			flag_r <= flag_nxt;
			cfg_r <= cfg_nxt;
			ifa_r <= ifa_nxt;
			pend_r <= pend_nxt;
			modes_r <= modes_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			rd_en_r <= rd_en_nxt;
			rd_r <= rd_nxt;
			sdo_r <= sdo_nxt;
			busy_r <= busy_nxt;
			conv_r <= conv_nxt;
			smp_r <= smp_nxt;
			sck_d_r <= sck_d_nxt;
			cnv_d_r <= cnv_d_nxt;
		end
	end

	assign link.sdo = sdo_r;
	assign link.conversion_flag_or_clock_out = busy_r;
	assign sample_strobe_out = smp_r;
	assign reset_active_out = hold_r;
	assign lockout_out = lock_out_r;
	assign cfg_mode_out = cfg_r;
	assign reset_seen_flag_out = flag_r;
	assign modes_out = modes_r;
endmodule : adc_seq_dev
`default_nettype wire

/* File: core/adc_seq_host.sv */
// Host end: power-up wait, reset pulse, lockout, serial frames, convert, mux
`timescale 1ns/1ps
`default_nettype none
module adc_seq_host #(
	parameter int DELAY_CYC = adc_seq_pkg::RESET_DELAY_CYC,
	parameter int LOCK_CYC = adc_seq_pkg::LOCKOUT_CYC,
	parameter int HALF_CYC = adc_seq_pkg::SCK_HALF_CYC,
	parameter int QUIET_CYC = adc_seq_pkg::QUIET_WINDOW_CYC,
	parameter int MUX_W = 4
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Link
	adc_link_if.host link,
	// Register command
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [14:0] cmd_addr_in,
	input wire logic [7:0] cmd_data_in,
	output logic cmd_ready_out,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	// Reset and convert requests
	input wire logic reset_req_in,
	input wire logic conv_req_in,
	// Multiplexer
	input wire logic mux_req_in,
	input wire logic [MUX_W-1:0] mux_sel_in,
	output logic [MUX_W-1:0] mux_sel_out
);
	localparam int W = adc_seq_pkg::CNT_W;
	typedef enum logic [5:0] {
		ST_PWRUP = 6'h01,
		ST_RST = 6'h02,
		ST_LOCK = 6'h04,
		ST_IDLE = 6'h08,
		ST_XFER = 6'h10,
		ST_CNV = 6'h20
	} host_state_t;

	// Synchronisers for device outputs
	logic [1:0] s1_r;
	logic [1:0] s2_r;
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s1_r <= 2'h0;
			s2_r <= 2'h0;
		end else begin
			s1_r <= {link.sdo, link.conversion_flag_or_clock_out};
			s2_r <= s1_r;
		end
	end

	host_state_t st_r, st_nxt;
	logic [W-1:0] cnt_r, cnt_nxt;
	logic rst_n_r, rst_n_nxt;
	logic cs_n_r, cs_n_nxt;
	logic sck_r, sck_nxt;
	logic sdi_r, sdi_nxt;
	logic cnv_r, cnv_nxt;
	logic [23:0] tx_r, tx_nxt;
	logic [4:0] bit_r, bit_nxt;
	logic rd_en_r, rd_en_nxt;
	logic [7:0] rd_r, rd_nxt;
	logic rdv_r, rdv_nxt;
	logic rdy_r, rdy_nxt;
	logic [MUX_W-1:0] mux_r, mux_nxt;
	logic [MUX_W-1:0] pend_r, pend_nxt;
	logic pend_v_r, pend_v_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		rst_n_nxt = rst_n_r;
		cs_n_nxt = cs_n_r;
		sck_nxt = sck_r;
		sdi_nxt = sdi_r;
		cnv_nxt = cnv_r;
		tx_nxt = tx_r;
		bit_nxt = bit_r;
		rd_en_nxt = rd_en_r;
		rd_nxt = rd_r;
		rdv_nxt = 1'b0;
		mux_nxt = mux_r;
		pend_nxt = pend_r;
		pend_v_nxt = pend_v_r;
		if (mux_req_in) begin
			pend_nxt = mux_sel_in;
			pend_v_nxt = 1'b1;
		end
		case (st_r)
			ST_PWRUP: begin
				cnt_nxt = cnt_r - W'(1);
				if (cnt_r == W'(1)) begin
					st_nxt = ST_RST;
					rst_n_nxt = 1'b0;
					cnt_nxt = W'(adc_seq_pkg::RESET_PULSE_CYC);
				end
			end
			ST_RST: begin
				cnt_nxt = cnt_r - W'(1);
				if (cnt_r == W'(1)) begin
					st_nxt = ST_LOCK;
					rst_n_nxt = 1'b1;
					cnt_nxt = W'(LOCK_CYC);
				end
			end
			ST_LOCK: begin
				cnt_nxt = cnt_r - W'(1);
				if (cnt_r == W'(1)) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (reset_req_in) begin
					st_nxt = ST_RST;
					rst_n_nxt = 1'b0;
					cnt_nxt = W'(adc_seq_pkg::RESET_PULSE_CYC);
				end else if (conv_req_in) begin
					st_nxt = ST_CNV;
					cnv_nxt = 1'b1;
					cnt_nxt = W'(QUIET_CYC);
				end else if (cmd_valid_in) begin
					st_nxt = ST_XFER;
					tx_nxt = {!cmd_write_in, cmd_addr_in, cmd_data_in};
					rd_en_nxt = !cmd_write_in;
					cs_n_nxt = 1'b0;
					sdi_nxt = !cmd_write_in;
					bit_nxt = 5'h00;
					cnt_nxt = W'(HALF_CYC);
				end else if (pend_v_r && !s2_r[0]) begin
					mux_nxt = pend_r;
					pend_v_nxt = mux_req_in;
				end
			end
			ST_XFER: begin
				cnt_nxt = cnt_r - W'(1);
				if (cnt_r == W'(1)) begin
					cnt_nxt = W'(HALF_CYC);
					if (bit_r == 5'(adc_seq_pkg::FRAME_BITS)) begin
						st_nxt = ST_IDLE;
						cs_n_nxt = 1'b1;
						// Park the clock low, else it idles high after the 24th rise
						sck_nxt = 1'b0;
						sdi_nxt = 1'b0;
						rdv_nxt = rd_en_r;
					end else if (!sck_r) begin
						sck_nxt = 1'b1;
						bit_nxt = bit_r + 5'h01;
						if (bit_r >= 5'(adc_seq_pkg::HDR_BITS)) begin
							rd_nxt = {rd_r[6:0], s2_r[1]};
						end
					end else begin
						sck_nxt = 1'b0;
						tx_nxt = {tx_r[22:0], 1'b0};
						sdi_nxt = tx_r[22];
					end
				end
			end
			ST_CNV: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - W'(1);
					if (cnt_r == W'(1)) begin
						cnv_nxt = 1'b0;
					end
				end else if (!s2_r[0]) begin
					st_nxt = ST_IDLE;
					if (pend_v_r) begin
						mux_nxt = pend_r;
						pend_v_nxt = mux_req_in;
					end
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		rdy_nxt = (st_nxt == ST_IDLE) && !(st_r == ST_IDLE && cmd_valid_in);
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_r <= ST_PWRUP;
			cnt_r <= W'(DELAY_CYC);
			rst_n_r <= 1'b1;
			cs_n_r <= 1'b1;
			sck_r <= 1'b0;
			sdi_r <= 1'b0;
			cnv_r <= 1'b0;
			tx_r <= 24'h000000;
			bit_r <= 5'h00;
			rd_en_r <= 1'b0;
			rd_r <= 8'h00;
			rdv_r <= 1'b0;
			rdy_r <= 1'b0;
			mux_r <= '0;
			pend_r <= '0;
			pend_v_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			rst_n_r <= rst_n_nxt;
			cs_n_r <= cs_n_nxt;
			sck_r <= sck_nxt;
			sdi_r <= sdi_nxt;
			cnv_r <= cnv_nxt;
			tx_r <= tx_nxt;
			bit_r <= bit_nxt;
			rd_en_r <= rd_en_nxt;
			rd_r <= rd_nxt;
			rdv_r <= rdv_nxt;
			rdy_r <= rdy_nxt;
			mux_r <= mux_nxt;
			pend_r <= pend_nxt;
			pend_v_r <= pend_v_nxt;
		end
	end

	assign link.rst_n = rst_n_r;
	assign link.cs_n = cs_n_r;
	assign link.sck = sck_r;
	assign link.sdi = sdi_r;
	assign link.convert_strobe = cnv_r;
	assign cmd_ready_out = rdy_r;
	assign rd_data_out = rd_r;
	assign rd_valid_out = rdv_r;
	assign mux_sel_out = mux_r;
endmodule : adc_seq_host
`default_nettype wire

/* File: test/adc_link_properties.sv */
// Link checker for the host and converter ends
`timescale 1ns/1ps
`default_nettype none
module adc_link_properties #(
	parameter int DELAY_CYC = 20,
	parameter int LOCK_CYC = 50,
	parameter int CONV_CYC = 10
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Link signals
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic convert_strobe,
	input wire logic sdo,
	input wire logic conversion_flag_or_clock_out
);
	int since_rel_r;
	int since_rise_r;
	int low_cnt_r;
	int rise_cnt_r;
	int busy_cnt_r;
	logic sck_q_r;
	logic busy;
	assign busy = conversion_flag_or_clock_out;
	// since_rel_r and since_rise_r saturate, so long idle stretches cannot wrap
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			since_rel_r <= 0;
			since_rise_r <= 0;
			low_cnt_r <= 0;
			rise_cnt_r <= 0;
			busy_cnt_r <= 0;
			sck_q_r <= 1'b0;
		end else begin
			since_rel_r <= (since_rel_r < DELAY_CYC) ? since_rel_r + 1 : since_rel_r;
			since_rise_r <= !rst_n ? 0 : ((since_rise_r < LOCK_CYC) ? since_rise_r + 1 : LOCK_CYC);
			low_cnt_r <= rst_n ? 0 : low_cnt_r + 1;
			rise_cnt_r <= cs_n ? 0 : rise_cnt_r + ((sck && !sck_q_r) ? 1 : 0);
			busy_cnt_r <= busy ? busy_cnt_r + 1 : 0;
			sck_q_r <= sck;
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	chk_reset_pulse_width: assert property (
		$rose(rst_n) |-> low_cnt_r >= adc_seq_pkg::RESET_PULSE_CYC)
		else $error("reset pin pulse too short");
	chk_power_up_delay: assert property (
		$fell(rst_n) |-> since_rel_r >= DELAY_CYC)
		else $error("reset pin lowered too soon after power-up");
	chk_lockout_quiet_link: assert property (
		(since_rise_r < LOCK_CYC) |-> (cs_n && !convert_strobe))
		else $error("frame or conversion started during lockout");
	chk_frame_clock_count: assert property (
		$rose(cs_n) |-> rise_cnt_r == adc_seq_pkg::FRAME_BITS)
		else $error("frame without exactly 24 serial clocks");
	chk_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("serial clock moves outside a frame");
	chk_sdi_held_high: assert property (
		(sck && $past(sck)) |-> $stable(sdi))
		else $error("data changed while serial clock high");
	chk_strobe_starts_busy: assert property (
		$rose(convert_strobe) |-> !busy ##[2:4] busy)
		else $error("busy did not follow the convert strobe");
	chk_busy_bounded_len: assert property (busy |-> busy_cnt_r < CONV_CYC)
		else $error("busy held longer than a conversion");
	chk_reset_aborts_busy: assert property (!rst_n [*6] |-> !busy)
		else $error("conversion not aborted by reset");
	chk_sdo_idle_low: assert property (cs_n [*4] |-> !sdo)
		else $error("read data line left driven after deselect");
	cov_frame_done: cover property ($rose(cs_n) && rise_cnt_r == adc_seq_pkg::FRAME_BITS);
	cov_conv_done: cover property ($fell(busy));
	cov_reset_pulse: cover property ($rose(rst_n));
endmodule : adc_link_properties
`default_nettype wire

/* File: test/adc_reset_and_sampling_sequencer_tb.sv */
// Self-checking bench for the converter reset and sequencing link
`timescale 1ns/1ps
`default_nettype none
module adc_reset_and_sampling_sequencer_tb;
	localparam int DELAY = 20;
	localparam int LOCK = 50;
	localparam int CONV = 10;
	logic core_clk_in, sys_rst_in, cmd_valid, cmd_write, cmd_ready, rd_valid;
	logic reset_req, conv_req, mux_req, ana_ok, core_ok;
	logic sample_pulse, reset_active, lockout, cfg_mode, seen_flag, bad;
	logic [14:0] cmd_addr;
	logic [7:0] cmd_data, rd_data, modes, got;
	logic [3:0] mux_sel, mux_out;
	int mismatches, checked, cycles;
	adc_link_if lnk ();
	// Host waits a little past the lockout so the device synchronisers catch up
	adc_seq_host #(.DELAY_CYC(DELAY), .LOCK_CYC(LOCK + 8), .HALF_CYC(10), .QUIET_CYC(16),
		.MUX_W(4)) adc_seq_host_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.link(lnk), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr),
		.cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .reset_req_in(reset_req), .conv_req_in(conv_req),
		.mux_req_in(mux_req), .mux_sel_in(mux_sel), .mux_sel_out(mux_out));
	adc_seq_dev #(.LOCK_CYC(LOCK), .CONV_CYC(CONV)) adc_seq_dev_i (.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in), .link(lnk), .analog_supply_high_ok_in(ana_ok),
		.core_supply_low_ok_in(core_ok), .sample_strobe_out(sample_pulse),
		.reset_active_out(reset_active), .lockout_out(lockout), .cfg_mode_out(cfg_mode),
		.reset_seen_flag_out(seen_flag), .modes_out(modes));
	adc_link_properties #(.DELAY_CYC(DELAY), .LOCK_CYC(LOCK), .CONV_CYC(CONV))
		adc_link_properties_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.rst_n(lnk.rst_n), .cs_n(lnk.cs_n), .sck(lnk.sck), .sdi(lnk.sdi),
		.convert_strobe(lnk.convert_strobe), .sdo(lnk.sdo),
		.conversion_flag_or_clock_out(lnk.conversion_flag_or_clock_out));
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	task automatic end_of_test();
		$display("counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			$display("MISMATCH at %0t: run did not finish", $time);
			end_of_test();
		end
	end
	task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask : check
	task automatic wait_ready();
		for (int n = 0; n < 3000 && cmd_ready !== 1'b1; n++)
			@(negedge core_clk_in);
	endtask : wait_ready
	// One whole 24-bit frame; read data lands in got
	task automatic cmd(input logic wr, input logic [14:0] addr, input logic [7:0] data);
		wait_ready();
		got = 8'hXX;
		cmd_write = wr;
		cmd_addr = addr;
		cmd_data = data;
		cmd_valid = 1'b1;
		@(negedge core_clk_in);
		cmd_valid = 1'b0;
		for (int n = 0; n < 3000 && cmd_ready !== 1'b1; n++) begin
			@(negedge core_clk_in);
			if (rd_valid === 1'b1)
				got = rd_data;
		end
	endtask : cmd
	task automatic pulse_reset_req();
		wait_ready();
		reset_req = 1'b1;
		@(negedge core_clk_in);
		reset_req = 1'b0;
	endtask : pulse_reset_req
	task automatic t_power_up();
		wait_ready();
		check(8'(seen_flag), 8'h01, "flag after power-up");
		check(modes, adc_seq_pkg::MODES_RST, "modes after power-up");
		check(8'(lockout), 8'h00, "lockout over at ready");
		$display("test power_up done");
	endtask : t_power_up
	task automatic t_flag_modes();
		cmd(1'b1, adc_seq_pkg::ADDR_DIAG, 8'h01);
		check(8'(seen_flag), 8'h01, "write outside config ignored");
		cmd(1'b0, adc_seq_pkg::ADDR_ENTER_CFG, 8'h00);
		check(8'(cfg_mode), 8'h01, "config entered");
		cmd(1'b1, adc_seq_pkg::ADDR_DIAG, 8'h00);
		check(8'(seen_flag), 8'h01, "zero write keeps flag");
		cmd(1'b1, adc_seq_pkg::ADDR_DIAG, 8'h01);
		check(8'(seen_flag), 8'h00, "one write clears flag");
		cmd(1'b0, adc_seq_pkg::ADDR_DIAG, 8'h00);
		check(got, 8'h00, "flag reads clear");
		cmd(1'b1, adc_seq_pkg::ADDR_MODES, 8'hA5);
		check(modes, adc_seq_pkg::MODES_RST, "modes pending");
		cmd(1'b1, adc_seq_pkg::ADDR_EXIT_CFG, adc_seq_pkg::EXIT_CFG_VAL);
		check(modes, 8'hA5, "modes applied at exit");
		check(8'(cfg_mode), 8'h00, "config left");
		$display("test flag_modes done");
	endtask : t_flag_modes
	task automatic t_soft_reset();
		int n;
		cmd(1'b0, adc_seq_pkg::ADDR_ENTER_CFG, 8'h00);
		cmd(1'b0, adc_seq_pkg::ADDR_MODES, 8'h00);
		check(got, 8'hA5, "modes read back");
		cmd(1'b1, adc_seq_pkg::ADDR_IFACE_A, 8'h80);
		cmd(1'b1, adc_seq_pkg::ADDR_IFACE_A, 8'h01);
		check(8'(seen_flag), 8'h00, "split bits no reset");
		check(modes, 8'hA5, "split bits keep modes");
		cmd(1'b1, adc_seq_pkg::ADDR_IFACE_A, 8'h81);
		check(8'(lockout), 8'h01, "soft reset lockout");
		check(modes, adc_seq_pkg::MODES_RST, "soft reset defaults");
		check(8'(seen_flag), 8'h01, "soft reset flag");
		// The host end does not track this lockout, so the bench waits it out
		for (n = 0; n < 200 && lockout === 1'b1; n++)
			@(negedge core_clk_in);
		check(8'(n <= LOCK), 8'h01, "lockout length");
		check(8'(cfg_mode), 8'h00, "soft reset leaves config");
		$display("test soft_reset done");
	endtask : t_soft_reset
	task automatic t_hw_reset();
		cmd(1'b0, adc_seq_pkg::ADDR_ENTER_CFG, 8'h00);
		cmd(1'b1, adc_seq_pkg::ADDR_DIAG, 8'h01);
		pulse_reset_req();
		for (int n = 0; n < 40 && reset_active !== 1'b1; n++)
			@(negedge core_clk_in);
		check(8'(reset_active), 8'h01, "pin reset taken");
		wait_ready();
		check(8'(seen_flag), 8'h01, "pin reset flag");
		check(8'(cfg_mode), 8'h00, "pin reset leaves config");
		$display("test hw_reset done");
	endtask : t_hw_reset
	task automatic t_conv_mux();
		int len;
		mux_sel = 4'h3;
		mux_req = 1'b1;
		@(negedge core_clk_in);
		mux_req = 1'b0;
		repeat (8) @(negedge core_clk_in);
		check(8'(mux_out), 8'h03, "idle mux applied");
		wait_ready();
		conv_req = 1'b1;
		@(negedge core_clk_in);
		conv_req = 1'b0;
		for (int n = 0; n < 20 && sample_pulse !== 1'b1; n++)
			@(negedge core_clk_in);
		check(8'(lnk.conversion_flag_or_clock_out), 8'h01, "busy with sample");
		mux_sel = 4'h9;
		mux_req = 1'b1;
		bad = 1'b0;
		for (len = 0; len < 200 && lnk.conversion_flag_or_clock_out === 1'b1; len++) begin
			@(negedge core_clk_in);
			mux_req = 1'b0;
			bad = bad | (mux_out !== 4'h3);
		end
		check(8'(bad), 8'h00, "mux held during conversion");
		check(8'(len), 8'(CONV), "busy length");
		repeat (8) @(negedge core_clk_in);
		check(8'(mux_out), 8'h09, "mux switched after conversion");
		$display("test conv_mux done");
	endtask : t_conv_mux
	task automatic t_supply();
		for (int k = 0; k < 2; k++) begin
			cmd(1'b0, adc_seq_pkg::ADDR_ENTER_CFG, 8'h00);
			cmd(1'b1, adc_seq_pkg::ADDR_DIAG, 8'h01);
			conv_req = 1'b1;
			@(negedge core_clk_in);
			conv_req = 1'b0;
			repeat (5) @(negedge core_clk_in);
			ana_ok = (k != 0);
			core_ok = (k == 0);
			repeat (6) @(negedge core_clk_in);
			check(8'(lnk.conversion_flag_or_clock_out), 8'h00, "dropout aborts");
			check(8'(reset_active), 8'h01, "dropout resets");
			ana_ok = 1'b1;
			core_ok = 1'b1;
			// Flag rises as the power-on reset releases, not while it holds
			repeat (DELAY) @(negedge core_clk_in);
			check(8'(seen_flag), 8'h01, "dropout sets flag");
			// Follow the power-on reset with a pin reset
			pulse_reset_req();
			wait_ready();
		end
		$display("test supply done");
	endtask : t_supply
	initial begin
		{cmd_valid, cmd_write, reset_req, conv_req, mux_req} = 5'h00;
		{ana_ok, core_ok} = 2'h3;
		cmd_addr = 15'h0000;
		cmd_data = 8'h00;
		mux_sel = 4'h0;
		mismatches = 0;
		checked = 0;
		cycles = 0;
		sys_rst_in = 1'b1;
		repeat (3) @(negedge core_clk_in);
		sys_rst_in = 1'b0;
		t_power_up();
		t_flag_modes();
		t_soft_reset();
		t_hw_reset();
		t_conv_mux();
		t_supply();
		end_of_test();
	end
endmodule : adc_reset_and_sampling_sequencer_tb
`default_nettype wire
